// >>> hw/lvr_reset_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "lvr_regs.svh"
module lvr_reset_ctrl
	import lvr_pkg::*;
#(
	parameter int WARMUP_NS = `LVR_WARMUP_NS,
	parameter int CNT_W = 16
) (
	input wire logic core_clk, // system clock
	input wire logic arst_n, // async reset
	input wire lvr_option_t detector_option, // factory detector option
	input wire logic reset_pin_enable, // pin option: reset function
	input wire logic ext_reset_n, // external reset pin
	input wire lvr_supply_t supply, // comparator levels
	input wire logic dead_band, // supply under minimum operating level
	input wire logic wdt_overflow, // watchdog overflow pulse
	input wire lvr_bus_req_t bus, // register port request
	input wire logic [2:0] alu_flags, // carry, half carry, zero from core
	input wire logic alu_flags_we, // core updates arithmetic flags
	output logic [7:0] rdata, // read data, cycle after read
	output logic system_reset, // registers held in initial state
	output logic cpu_run, // execution enabled
	output logic boot_valid, // pulse: fetch from boot address
	output logic [11:0] boot_address_zero // start address
);
	localparam int WARMUP_CYC_RAW = WARMUP_NS / `LVR_CLK_NS;
	localparam int WARMUP_CYC = (WARMUP_CYC_RAW < 1) ? 1 : WARMUP_CYC_RAW;
	// warm-up is fixed at build time; a slow crystal needs a larger WARMUP_NS
	localparam int INIT_CYC = `LVR_INIT_CYCLES;

	lvr_state_t state;
	lvr_state_t next_state;
	logic [1:0] cause;
	logic below_mid_flag;
	logic below_high_flag;
	logic [2:0] arith;
	logic detector_reset;
	logic pin_active;
	logic any_reset;
	logic cnt_load;
	logic [CNT_W-1:0] cnt_value;
	logic cnt_done;
	logic mid_en;
	logic high_en;
	logic flag_wr;
	logic flag_rd;
	logic cause_wr;
	logic [7:0] flag_byte;
	logic src_pin;
	logic src_detector;
	logic src_wdt;
	logic warmup_end;

	function automatic logic detector_trip(lvr_option_t opt, lvr_supply_t s);
		// low level trips reset; high option moves the trip to the mid level in its place
		detector_trip = s.below_low;
		if (opt == detector_option_high)
		begin
			// mid comparator stands for the reset level here
			detector_trip = s.below_mid;
		end
	endfunction : detector_trip

	function automatic logic hits_flag_reg(logic [7:0] addr);
		hits_flag_reg = (addr == `LVR_PROCESSOR_FLAG_REG_ADDR);
	endfunction : hits_flag_reg

	function automatic logic flag_armed(lvr_option_t opt, logic high_level);
		if (high_level)
		begin
			flag_armed = (opt == detector_option_high);
		end
		else
		begin
			flag_armed = (opt != detector_option_low);
		end
	endfunction : flag_armed

	function automatic logic [7:0] flag_byte_of(
		logic [1:0] c,
		logic hi,
		logic mid,
		logic [2:0] a
	);
		// the unused bit between flags and arithmetic always reads zero
		flag_byte_of = `LVR_REG_RESET;
		flag_byte_of[`LVR_BIT_CAUSE_UPPER] = c[1];
		flag_byte_of[`LVR_BIT_CAUSE_LOWER] = c[0];
		flag_byte_of[`LVR_BIT_BELOW_HIGH] = hi;
		flag_byte_of[`LVR_BIT_BELOW_MID] = mid;
		flag_byte_of[`LVR_BIT_CARRY] = a[2];
		flag_byte_of[`LVR_BIT_HALF_CARRY] = a[1];
		flag_byte_of[`LVR_BIT_ZERO] = a[0];
	endfunction : flag_byte_of

	assign detector_reset = detector_trip(detector_option, supply);
	assign pin_active = reset_pin_enable && !ext_reset_n;
	assign mid_en = flag_armed(detector_option, 1'b0);
	assign high_en = flag_armed(detector_option, 1'b1);
	// detector and pin act from any state, including power-up
	assign any_reset = detector_reset || pin_active || wdt_overflow;

	// one place for the cause priority: pin over detector over watchdog
	assign src_pin = pin_active;
	assign src_detector = detector_reset && !pin_active;
	assign src_wdt = wdt_overflow && !pin_active && !detector_reset;

	// bus decode; cause bits only take software writes while running
	assign flag_wr = bus.wr && hits_flag_reg(bus.addr);
	assign flag_rd = bus.rd && hits_flag_reg(bus.addr);
	assign cause_wr = flag_wr && cpu_run && !any_reset;
	assign flag_byte = flag_byte_of(cause, below_high_flag, below_mid_flag, arith);
	assign warmup_end = (state == st_warmup) && (next_state == st_run);

	// one counter serves both timed phases, so init and warm-up never overlap
	always_comb
	begin
		next_state = state;
		cnt_load = 1'b0;
		cnt_value = '0;
		unique case (state)
			st_hold:
			begin
				// a watchdog reset lands here too and waits out the dead band
				if (!detector_reset && !dead_band)
				begin
					next_state = st_pin_wait;
				end
			end
			st_pin_wait:
			begin
				if (!pin_active)
				begin
					next_state = st_init;
					cnt_load = 1'b1;
					cnt_value = CNT_W'(INIT_CYC);
				end
			end
			st_init:
			begin
				if (cnt_done)
				begin
					next_state = st_warmup;
					cnt_load = 1'b1;
					cnt_value = CNT_W'(WARMUP_CYC);
				end
			end
			st_warmup:
			begin
				// oscillator settles before the first fetch
				if (cnt_done)
				begin
					next_state = st_run;
				end
			end
			st_run:
			begin
				next_state = st_run;
			end
		endcase
		// any source overrides the sequence, whatever phase it is in
		if (any_reset)
		begin
			next_state = st_hold;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state <= st_hold;
		end
		else
		begin
			state <= next_state;
		end
	end

	// done is registered, so each timed phase runs one cycle past its count
	lvr_counter #(
		.W(CNT_W)
	) u_counter (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.load(cnt_load),
		.count(cnt_value),
		.done(cnt_done)
	);

	// execution is gated by the registered state alone, so cpu_run drops the cycle after a source asserts
	assign system_reset = (state != st_run);
	assign cpu_run = (state == st_run);

	// boot pulse marks the first run cycle
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			boot_valid <= 1'b0;
		end
		else
		begin
			boot_valid <= warmup_end;
		end
	end

	// restart point held constant, so a fetch never sees a stale address
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			boot_address_zero <= `LVR_BOOT_ADDR;
		end
		else
		begin
			boot_address_zero <= `LVR_BOOT_ADDR;
		end
	end

	// cause flags latch the latest reset source
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cause <= `LVR_CAUSE_POR;
		end
		else if (src_pin)
		begin
			cause <= `LVR_CAUSE_EXT;
		end
		else if (src_detector)
		begin
			cause <= `LVR_CAUSE_POR;
		end
		else if (src_wdt)
		begin
			cause <= `LVR_CAUSE_WDT;
		end
		else if (cause_wr)
		begin
			cause <= {bus.wdata[`LVR_BIT_CAUSE_UPPER], bus.wdata[`LVR_BIT_CAUSE_LOWER]};
		end
	end

	// mid indicator follows its comparator when armed, cleared while the detector trips; bus writes never reach it
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			below_mid_flag <= 1'b0;
		end
		else if (detector_reset)
		begin
			below_mid_flag <= 1'b0;
		end
		else
		begin
			below_mid_flag <= mid_en && supply.below_mid;
		end
	end

	// high indicator, same clearing with its own enable
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			below_high_flag <= 1'b0;
		end
		else if (detector_reset)
		begin
			below_high_flag <= 1'b0;
		end
		else
		begin
			below_high_flag <= high_en && supply.below_high;
		end
	end

	// arithmetic flags return to zero on any reset
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			arith <= '0;
		end
		else if (system_reset)
		begin
			arith <= '0;
		end
		else if (flag_wr)
		begin
			arith <= {bus.wdata[`LVR_BIT_CARRY], bus.wdata[`LVR_BIT_HALF_CARRY],
				bus.wdata[`LVR_BIT_ZERO]};
		end
		else if (alu_flags_we)
		begin
			arith <= alu_flags;
		end
	end

	// one-cycle read data; an idle bus reads zero, so stale bytes never linger
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rdata <= `LVR_REG_RESET;
		end
		else if (flag_rd)
		begin
			rdata <= flag_byte;
		end
		else
		begin
			rdata <= `LVR_REG_RESET;
		end
	end
endmodule : lvr_reset_ctrl
`default_nettype wire

// >>> hw/lvr_regs.svh
`ifndef LVR_REGS_SVH
`define LVR_REGS_SVH
`define LVR_PROCESSOR_FLAG_REG_ADDR 8'h86
`define LVR_BIT_CAUSE_UPPER 7
`define LVR_BIT_CAUSE_LOWER 6
`define LVR_BIT_BELOW_HIGH 5
`define LVR_BIT_BELOW_MID 4
`define LVR_BIT_CARRY 2
`define LVR_BIT_HALF_CARRY 1
`define LVR_BIT_ZERO 0
`define LVR_CAUSE_WDT 2'h0
`define LVR_CAUSE_POR 2'h2
`define LVR_CAUSE_EXT 2'h3
`define LVR_BOOT_ADDR 12'h000
`define LVR_INIT_CYCLES 4
`define LVR_WARMUP_NS 2048000
`define LVR_CLK_NS 40
`define LVR_REG_RESET 8'h00
`endif

// >>> hw/lvr_pkg.sv
package lvr_pkg;
	typedef enum logic [1:0] {
		detector_option_low,
		detector_option_mid,
		detector_option_high
	} lvr_option_t;
	typedef enum {
		st_hold,
		st_pin_wait,
		st_init,
		st_warmup,
		st_run
	} lvr_state_t;
	typedef struct packed {
		logic below_low;
		logic below_mid;
		logic below_high;
	} lvr_supply_t;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} lvr_bus_req_t;
endpackage : lvr_pkg

// >>> hw/lvr_counter.sv
`timescale 1ns/1ns
`default_nettype none
// down counter for the init and warm-up phases; done is a registered level
module lvr_counter #(
	parameter int W = 16
) (
	input wire logic core_clk, // clock
	input wire logic arst_n, // async reset
	input wire logic load, // load count
	input wire logic [W-1:0] count, // cycles to run
	output logic done // count reached zero
);
	logic [W-1:0] left;

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			left <= '0;
			done <= 1'b0;
		end
		else if (load)
		begin
			left <= count;
			done <= 1'b0;
		end
		else if (left != '0)
		begin
			left <= left - 1'b1;
			done <= (left == {{(W-1){1'b0}}, 1'b1});
		end
	end
endmodule : lvr_counter
`default_nettype wire

// >>> verif/lvr_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
module lvr_pin_model #(
	parameter int DLY = 3
) (
	input wire logic core_clk, // clock
	input wire logic press, // pull pin low
	output logic ext_reset_n // reset pin
);
	int cnt = 0;
	// slow rc-like release; high from power-up on
	always @(posedge core_clk) cnt <= press ? DLY : (cnt > 0 ? cnt - 1 : 0);
	assign ext_reset_n = (cnt == 0);
endmodule : lvr_pin_model
`default_nettype wire

// >>> verif/lvr_reset_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module lvr_reset_monitor
	import lvr_pkg::*;
(
	input wire logic core_clk, // clock
	input wire logic arst_n, // reset
	input wire lvr_option_t detector_option, // option
	input wire logic reset_pin_enable, // pin on
	input wire logic ext_reset_n, // pin
	input wire lvr_supply_t supply, // levels
	input wire logic dead_band, // dead band
	input wire logic wdt_overflow, // wdt
	input wire logic system_reset, // reset out
	input wire logic cpu_run, // run
	input wire logic boot_valid // boot
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	property p_low; supply.below_low |=> system_reset; endproperty
	a_low: assert property (p_low) else $error("low trip");
	property p_high; detector_option == detector_option_high && supply.below_mid |=> system_reset;
	endproperty
	a_high: assert property (p_high) else $error("high trip");
	property p_pin; reset_pin_enable && !ext_reset_n |=> system_reset; endproperty
	a_pin: assert property (p_pin) else $error("pin");
	property p_wdt; wdt_overflow |=> system_reset; endproperty
	a_wdt: assert property (p_wdt) else $error("wdt");
	property p_dead; dead_band && system_reset |=> system_reset; endproperty
	a_dead: assert property (p_dead) else $error("dead");
	property p_boot; $rose(cpu_run) |-> boot_valid; endproperty
	a_boot: assert property (p_boot) else $error("boot");
	property p_seq; $rose(cpu_run) |-> $past(system_reset, 5); endproperty
	a_seq: assert property (p_seq) else $error("seq");
	property p_halt; system_reset |-> !cpu_run && !boot_valid; endproperty
	a_halt: assert property (p_halt) else $error("halt");
endmodule : lvr_reset_monitor
bind lvr_reset_ctrl lvr_reset_monitor u_mon (.core_clk, .arst_n, .detector_option,
	.reset_pin_enable, .ext_reset_n, .supply, .dead_band, .wdt_overflow, .system_reset,
	.cpu_run, .boot_valid);
`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb import lvr_pkg::*;;
	logic core_clk, arst_n, reset_pin_enable, dead_band, wdt_overflow, press;
	logic ext_reset_n, system_reset, cpu_run, boot_valid;
	lvr_option_t detector_option;
	lvr_supply_t supply;
	lvr_bus_req_t bus;
	logic [7:0] rdata, d;
	logic [11:0] boot_address_zero;
	int mismatches = 0;
	int n_tests = 0;
	lvr_pin_model u_pin (.core_clk, .press, .ext_reset_n);
	lvr_reset_ctrl #(.WARMUP_NS(400)) u_dut (.core_clk, .arst_n, .detector_option,
		.reset_pin_enable, .ext_reset_n, .supply, .dead_band, .wdt_overflow, .bus,
		.alu_flags(3'h0), .alu_flags_we(1'b0), .rdata, .system_reset, .cpu_run,
		.boot_valid, .boot_address_zero);
	task chk(input logic [11:0] g, input logic [11:0] e);
		n_tests++;
		if (g !== e)
		begin
			mismatches++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : cyc
	task rd(input logic [7:0] a);
		@(posedge core_clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge core_clk) bus <= '0;
		#1 d = rdata;
	endtask : rd
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge core_clk) bus <= '{a, v, 1'b1, 1'b0};
		@(posedge core_clk) bus <= '0;
	endtask : wr
	task wrun;
		for (int i = 0; i < 100 && cpu_run !== 1'b1; i++)
			cyc(1);
		chk(cpu_run, 1'b1);
	endtask : wrun
	task fl(input lvr_option_t o, input lvr_supply_t s, input logic [7:0] e);
		detector_option <= o;
		supply <= s;
		cyc(3);
		rd(8'h86);
		chk(d & 8'h30, e);
	endtask : fl
	task t_boot;
		wrun;
		chk(boot_valid, 1'b1);
		chk(boot_address_zero, 12'h000);
		rd(8'h86);
		chk(d, 8'h80);
	endtask : t_boot
	task t_pin;
		press <= 1'b1;
		cyc(8);
		chk(system_reset, 1'b1);
		press <= 1'b0;
		wrun;
		rd(8'h86);
		chk(d, 8'hc0);
		reset_pin_enable <= 1'b0;
		press <= 1'b1;
		cyc(8);
		chk(cpu_run, 1'b1);
		press <= 1'b0;
		cyc(8);
		reset_pin_enable <= 1'b1;
	endtask : t_pin
	task t_wdt;
		dead_band <= 1'b1;
		wdt_overflow <= 1'b1;
		cyc(1);
		wdt_overflow <= 1'b0;
		cyc(20);
		chk(system_reset, 1'b1);
		dead_band <= 1'b0;
		wrun;
		rd(8'h86);
		chk(d, 8'h00);
	endtask : t_wdt
	task t_flags;
		fl(detector_option_low, 3'b011, 8'h00);
		fl(detector_option_mid, 3'b011, 8'h10);
		fl(detector_option_mid, 3'b001, 8'h00);
		fl(detector_option_high, 3'b001, 8'h20);
		supply <= 3'b011;
		cyc(3);
		chk(system_reset, 1'b1);
		rd(8'h86);
		chk(d & 8'h30, 8'h00);
		supply <= 3'b000;
		wrun;
		rd(8'h86);
		chk(d, 8'h80);
		detector_option <= detector_option_low;
		supply <= 3'b111;
		cyc(3);
		chk(system_reset, 1'b1);
		supply <= 3'b000;
		wrun;
	endtask : t_flags
	task t_reg;
		detector_option <= detector_option_mid;
		wr(8'h86, 8'hff);
		rd(8'h86);
		chk(d, 8'hc7);
		wdt_overflow <= 1'b1;
		cyc(1);
		wdt_overflow <= 1'b0;
		wrun;
		rd(8'h86);
		chk(d, 8'h00);
		rd(8'h55);
		chk(d, 8'h00);
	endtask : t_reg
	task final_report;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report
	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	// a full pass needs well under 1000 cycles
	initial
	begin
		#200000;
		mismatches++;
		final_report;
	end
	initial
	begin
		arst_n = 1'b0;
		reset_pin_enable = 1'b1;
		dead_band = 1'b0;
		wdt_overflow = 1'b0;
		press = 1'b0;
		detector_option = detector_option_mid;
		supply = '0;
		bus = '0;
		repeat (12) @(posedge core_clk);
		arst_n <= 1'b1;
		t_boot;
		t_pin;
		t_wdt;
		t_flags;
		t_reg;
		final_report;
	end
endmodule : tb
`default_nettype wire
